// ---- hw/sapi_pkg.sv ----
// shared types and constants for the sdram address pin interface
package sapi_pkg;
    localparam int BANK_W = 3;                 // eight banks
    localparam int ROW_W = 15;
    localparam int COL_W = 10;
    localparam int CA_W = 6;
    localparam int DQ_W = 16;
    localparam int LANES = 2;
    localparam int LANE_W = 8;
    localparam int DBI_LIM = 4;                // more ones sends a lane inverted
    localparam logic [1:0] COL_LOW = 2'h0;     // column bits never sent
    localparam logic [1:0] LANE_ON = 2'h0;     // active-low lane enables
    localparam logic [1:0] LANE_OFF = 2'h3;
    localparam logic [3:0] WR_BEATS = 4'h8;    // data beats per write burst
    localparam logic [3:0] WCNT_ZERO = 4'h0;
    localparam logic [3:0] WCNT_ONE = 4'h1;
    // link-side event queue, deep enough for a command plus a write burst
    localparam int EVQ_AW = 3;
    localparam int EVQ_DEPTH = 8;
    localparam logic [EVQ_AW:0] EVQ_FULL = 4'h8;
    localparam logic [EVQ_AW:0] EVQ_EMPTY = 4'h0;
    localparam logic [EVQ_AW:0] EVQ_ONE = 4'h1;
    localparam logic [EVQ_AW-1:0] EVQ_STEP = 3'h1;
    // first-half opcodes on command lines 4..1
    localparam logic [3:0] OP_RD1 = 4'h1;
    localparam logic [3:0] OP_WR1 = 4'h2;
    localparam logic [3:0] OP_REF = 4'h4;
    localparam logic [3:0] OP_MWR1 = 4'h6;
    localparam logic [3:0] OP_PRE = 4'h8;
    localparam logic [3:0] OP_CAS2 = 4'h9;

    typedef enum logic [2:0] {
        EV_ACT, EV_RD, EV_WR, EV_MWR, EV_PRE, EV_REF, EV_WDAT, EV_NONE
    } sapi_kind_t;

    // first half of a command as it sits on the command lines
    typedef struct packed {
        logic hi;                              // line 5
        logic [3:0] op;                        // lines 4..1
        logic act;                             // line 0
    } sapi_ca_t;

    // second half of a bank-oriented command
    typedef struct packed {
        logic [1:0] hi;                        // lines 5..4
        logic v;                               // line 3
        logic [BANK_W-1:0] bank;               // lines 2..0
    } sapi_ca2_t;

    // one decoded event handed to the core side
    typedef struct packed {
        sapi_kind_t kind;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic ap;                              // auto precharge or all banks
        logic [DQ_W-1:0] data;
        logic [LANES-1:0] be;                  // byte lanes kept
    } sapi_ev_t;

    // mode settings that steer the data lanes
    typedef struct packed {
        logic dbi_rd;
        logic dbi_wr;
        logic dm_en;
    } sapi_cfg_t;
endpackage : sapi_pkg

// ---- hw/sapi_buf.sv ----
// two-entry event buffer with registered valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sapi_buf
    import sapi_pkg::*;
(
    input wire logic clk,                      // core clock
    input wire logic nrst,                     // async reset, active low
    input wire logic ce,                       // freezes the buffer when low
    input wire logic in_valid,                 // word offered
    output logic in_ready,                     // room for a word
    input wire sapi_ev_t in_data,              // offered word
    output logic out_valid,                    // word available
    input wire logic out_ready,                // drain side takes it
    output sapi_ev_t out_data                  // head word
);
    typedef struct packed {
        logic ov;
        sapi_ev_t od;
        logic sv;
        sapi_ev_t sd;
        logic ir;
    } sapi_bst_t;

    sapi_bst_t q;
    sapi_bst_t d;

    // head slot refills from the skid slot first so order is kept
    always_comb begin
        d = q;
        if (out_ready || !q.ov) begin
            if (q.sv) begin
                d.od = q.sd;
                d.ov = 1'b1;
                d.sv = 1'b0;
            end else begin
                d.od = in_data;
                d.ov = in_valid && q.ir;
            end
        end else if (in_valid && q.ir) begin
            d.sd = in_data;
            d.sv = 1'b1;
        end
        d.ir = !d.sv;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.ir <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    assign in_ready = q.ir;
    assign out_valid = q.ov;
    assign out_data = q.od;
endmodule : sapi_buf
`default_nettype wire

// ---- hw/sapi_top.sv ----
// device-side command decode and data lanes of the sdram pin interface
// Function
// - the channel holds eight banks picked by a three-bit bank field.
// - the two lowest column bits are never sent and read as zero.
// - all command inputs are sampled on the rising true clock edge.
// - clock gate high runs the input logic and drivers, low stops them.
// - each command is decoded from select, six lines and clock gate.
// - on reads the device makes the strobe, edge aligned with data.
// - each byte lane has its own strobe pair and mask/invert line.
// - the driver sets a lane's mask/invert line high when inverted.
// - on writes the mask/invert line carries masking when selected.
// - the active-low reset returns everything to reset from any state.
// - command termination follows the control pin and its mode bit.
// - commands take two cycles, select at the first; deselect one.
// - the three bank bits in a command pick the bank it acts on.
`timescale 1ns/1ns
`default_nettype none
module sapi_top
    import sapi_pkg::*;
(
    input wire logic clk,                      // core clock, 125 MHz
    input wire logic nrst,                     // async reset pin, active low
    input wire logic ce,                       // core clock enable
    input wire logic ck_t,                     // link clock, true phase
    input wire logic cke,                      // clock gate, link domain
    input wire logic cs,                       // chip select
    input wire logic [CA_W-1:0] cmd_addr_bus,  // command/address lines
    input wire logic [DQ_W-1:0] data_i,        // data pins, input side
    output logic [DQ_W-1:0] data_o,            // data pins, output side
    input wire logic [LANES-1:0] mask_invert_line_i, // per lane, input
    output logic [LANES-1:0] mask_invert_line_o, // per lane, output
    output logic [LANES-1:0] strobe_t_o,       // read strobe, true
    output logic [LANES-1:0] strobe_c_o,       // read strobe, complement
    output logic [LANES-1:0] lane_oe_n,        // lane driver enable, low on
    input wire sapi_cfg_t cfg_i,               // mode settings, core side
    input wire logic term_mode_en,             // termination mode bit
    input wire logic cmd_term_ctl,             // termination control pin
    output logic term_on,                      // command termination active
    output logic ev_valid,                     // decoded event ready
    input wire logic ev_ready,                 // core consumer takes event
    output sapi_ev_t ev_data,                  // decoded event
    input wire logic rd_valid,                 // read word offered
    output logic rd_ready,                     // read path can take a word
    input wire logic [DQ_W-1:0] rd_data,       // read word
    output logic ev_overrun                    // link event dropped, sticky
);
    typedef enum logic {LS_IDLE, LS_HALF2} sapi_lst_t;

    // everything clocked by the link clock
    typedef struct packed {
        sapi_lst_t st;
        logic [CA_W-1:0] op1;
        sapi_kind_t pk;
        logic [BANK_W-1:0] bank;
        logic [4:0] act_hi;
        logic c9;
        logic ap;
        logic [3:0] wcnt;
        sapi_ev_t ev;
        logic req;
        logic ack1;
        logic ack2;
        logic ovr;
        sapi_ev_t [EVQ_DEPTH-1:0] fq;          // events waiting for the core
        logic [EVQ_AW-1:0] wp;
        logic [EVQ_AW-1:0] rp;
        logic [EVQ_AW:0] fcnt;
        sapi_cfg_t cfg1;
        sapi_cfg_t cfg2;
        logic rdt1;
        logic rdt2;
        logic rack;
        logic [DQ_W-1:0] dq;
        logic [LANES-1:0] mask_invert_line;
        logic [LANES-1:0] dqs;
        logic [LANES-1:0] dqsc;
        logic [LANES-1:0] oe_n;
    } sapi_lnk_t;

    // everything clocked by the core clock
    typedef struct packed {
        logic term1;
        logic term2;
        logic term_on;
        logic evr1;
        logic evr2;
        logic evack;
        logic rtgl;
        logic rack1;
        logic rack2;
        logic rdy;
        logic [DQ_W-1:0] rword;
    } sapi_core_t;

    sapi_lnk_t lq;
    sapi_lnk_t ld;
    sapi_core_t cq;
    sapi_core_t cd;
    logic [1:0] lrs_q;
    logic lrst_n;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [LANES-1:0] rd_inv;
    logic [DQ_W-1:0] rd_enc;
    logic [LANES-1:0] wr_be;
    logic [DQ_W-1:0] wr_dat;

    // reset asserts at once and leaves the link domain on its own edge
    always_ff @(posedge ck_t or negedge nrst) begin
        if (!nrst) begin
            lrs_q <= 2'h0;
        end else begin
            lrs_q <= {lrs_q[0], 1'b1};
        end
    end
    assign lrst_n = lrs_q[1];

    // per-lane encode and decode of the mask/invert line
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LANE_W-1:0] rb;
        logic [LANE_W-1:0] wb;
        logic wi;
        assign rb = cq.rword[l*LANE_W +: LANE_W];
        assign wb = data_i[l*LANE_W +: LANE_W];
        assign wi = mask_invert_line_i[l];
        // read lanes invert when that lowers the ones on the wire
        assign rd_inv[l] = lq.cfg2.dbi_rd && ($countones(rb) > DBI_LIM);
        assign rd_enc[l*LANE_W +: LANE_W] = rd_inv[l] ? ~rb : rb;
        // mask mode wins: the line then cannot also flag inversion
        assign wr_be[l] = !(lq.cfg2.dm_en && wi);
        assign wr_dat[l*LANE_W +: LANE_W] =
            (lq.cfg2.dbi_wr && !lq.cfg2.dm_en && wi) ? ~wb : wb;
    end

    // link side: command decode, write beats and read beats
    always_comb begin
        logic busy;
        logic cmd_go;
        logic beat_go;
        sapi_ev_t cev;
        sapi_ca_t f;
        sapi_ca2_t s;
        logic push;
        logic pop;
        busy = lq.req != lq.ack2;
        cmd_go = 1'b0;
        beat_go = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        cev = '0;
        cev.kind = EV_NONE;
        f = sapi_ca_t'(lq.op1);
        s = sapi_ca2_t'(cmd_addr_bus);
        ld = lq;
        ld.cfg1 = cfg_i;
        ld.cfg2 = lq.cfg1;
        ld.ack1 = cq.evack;
        ld.ack2 = lq.ack1;
        ld.rdt1 = cq.rtgl;
        ld.rdt2 = lq.rdt1;
        // drivers fall back to released unless a read beat goes out
        ld.oe_n = LANE_OFF;
        if (cke) begin
            // a write beat is sampled on the same edge as the commands
            if (lq.wcnt != WCNT_ZERO) begin
                ld.wcnt = lq.wcnt - WCNT_ONE;
                beat_go = 1'b1;
            end
            case (lq.st)
                LS_IDLE: begin
                    // select high marks the first half; low is deselect
                    if (cs) begin
                        ld.op1 = cmd_addr_bus;
                        ld.st = LS_HALF2;
                    end
                end
                LS_HALF2: begin
                    ld.st = LS_IDLE;
                    if (f.act) begin
                        if (!f.op[0]) begin
                            // first activate half: upper row bits, bank
                            ld.act_hi = {f.op[3:1], s.hi};
                            ld.bank = s.bank;
                        end else begin
                            cev.kind = EV_ACT;
                            cev.bank = lq.bank;
                            cev.row = {lq.act_hi, f.hi, f.op[3:1],
                                cmd_addr_bus};
                            cmd_go = 1'b1;
                        end
                    end else begin
                        case (f.op)
                            OP_RD1, OP_WR1, OP_MWR1: begin
                                ld.pk = (f.op == OP_RD1) ? EV_RD :
                                    (f.op == OP_WR1) ? EV_WR : EV_MWR;
                                ld.bank = s.bank;
                                ld.c9 = s.hi[0];
                                ld.ap = s.hi[1];
                            end
                            OP_CAS2: begin
                                // a column half without its opener is dropped
                                if (lq.pk != EV_NONE) begin
                                    cev.kind = lq.pk;
                                    cev.bank = lq.bank;
                                    cev.ap = lq.ap;
                                    cev.col = {lq.c9, f.hi, cmd_addr_bus,
                                        COL_LOW};
                                    cmd_go = 1'b1;
                                    ld.pk = EV_NONE;
                                    if (lq.pk != EV_RD) begin
                                        ld.wcnt = WR_BEATS;
                                    end
                                end
                            end
                            OP_PRE, OP_REF: begin
                                cev.kind = (f.op == OP_PRE) ? EV_PRE : EV_REF;
                                cev.bank = s.bank;
                                cev.ap = f.hi;
                                cmd_go = 1'b1;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                default: begin
                    ld.st = LS_IDLE;
                end
            endcase
            // a beat outranks a command that lands in the same cycle
            if (beat_go) begin
                if (cmd_go) begin
                    ld.ovr = 1'b1;
                end
                cev = '0;
                cev.kind = EV_WDAT;
                cev.data = wr_dat;
                cev.be = wr_be;
                cmd_go = 1'b1;
            end
            // beats come every link cycle but a handshake takes three,
            // so events park here and leave in order
            if (cmd_go) begin
                if (lq.fcnt == EVQ_FULL) begin
                    ld.ovr = 1'b1;
                end else begin
                    ld.fq[lq.wp] = cev;
                    ld.wp = lq.wp + EVQ_STEP;
                    push = 1'b1;
                end
            end
            // the held word may change only after the core took it
            if (!busy && lq.fcnt != EVQ_EMPTY) begin
                ld.ev = lq.fq[lq.rp];
                ld.req = ~lq.req;
                ld.rp = lq.rp + EVQ_STEP;
                pop = 1'b1;
            end
            if (push && !pop) begin
                ld.fcnt = lq.fcnt + EVQ_ONE;
            end else if (pop && !push) begin
                ld.fcnt = lq.fcnt - EVQ_ONE;
            end
            // read beat: strobe flips on the edge that launches data
            if (lq.rdt2 != lq.rack) begin
                ld.rack = lq.rdt2;
                ld.dq = rd_enc;
                ld.mask_invert_line = rd_inv;
                ld.dqs = ~lq.dqs;
                ld.dqsc = lq.dqs;
                ld.oe_n = LANE_ON;
            end
        end
    end

    always_ff @(posedge ck_t or negedge lrst_n) begin
        if (!lrst_n) begin
            lq <= '0;
            lq.pk <= EV_NONE;
            lq.dqsc <= LANE_OFF;
            lq.oe_n <= LANE_OFF;
        end else begin
            lq <= ld;
        end
    end

    // core side: termination, event handshake and read word hand-off
    always_comb begin
        cd = cq;
        cd.term1 = cmd_term_ctl;
        cd.term2 = cq.term1;
        cd.term_on = cq.term2 && term_mode_en;
        cd.evr1 = lq.req;
        cd.evr2 = cq.evr1;
        cd.rack1 = lq.rack;
        cd.rack2 = cq.rack1;
        if (buf_in_valid && buf_in_ready) begin
            cd.evack = cq.evr2;
        end
        // one read word in flight; freed once the link echoes it
        if (cq.rdy && rd_valid) begin
            cd.rword = rd_data;
            cd.rtgl = ~cq.rtgl;
            cd.rdy = 1'b0;
        end else if (!cq.rdy && cq.rack2 == cq.rtgl) begin
            cd.rdy = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cq <= '0;
            cq.rdy <= 1'b1;
        end else if (ce) begin
            cq <= cd;
        end
    end

    // a full buffer withholds the ack, which stalls the link side
    assign buf_in_valid = cq.evr2 != cq.evack;

    sapi_buf u_buf (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(lq.ev),
        .out_valid(ev_valid),
        .out_ready(ev_ready),
        .out_data(ev_data)
    );

    assign data_o = lq.dq;
    assign mask_invert_line_o = lq.mask_invert_line;
    assign strobe_t_o = lq.dqs;
    assign strobe_c_o = lq.dqsc;
    assign lane_oe_n = lq.oe_n;
    assign term_on = cq.term_on;
    assign rd_ready = cq.rdy;
    assign ev_overrun = lq.ovr;

    // select high while idle opens a two-cycle command
    property p_first_half;
        @(posedge ck_t) disable iff (!lrst_n)
        (cke && cs && lq.st == LS_IDLE) |=>
            (lq.st == LS_HALF2 && lq.op1 == $past(cmd_addr_bus));
    endproperty
    a_first_half: assert property (p_first_half)
        else $error("first half not captured on rising clock");

    // the second half always closes the command
    property p_two_cycle;
        @(posedge ck_t) disable iff (!lrst_n)
        (cke && lq.st == LS_HALF2) |=> (lq.st == LS_IDLE);
    endproperty
    a_two_cycle: assert property (p_two_cycle)
        else $error("command did not end after its second cycle");

    // precharge carries the bank of its second half
    property p_bank;
        @(posedge ck_t) disable iff (!lrst_n)
        (cke && lq.st == LS_HALF2 && !lq.op1[0] && lq.wcnt == WCNT_ZERO
            && lq.op1[4:1] == OP_PRE && lq.fcnt != EVQ_FULL) |=>
            (lq.fq[$past(lq.wp)].kind == EV_PRE
            && lq.fq[$past(lq.wp)].bank == $past(cmd_addr_bus[2:0]));
    endproperty
    a_bank: assert property (p_bank)
        else $error("precharge bank differs from its bank bits");

    // every column handed to the core starts on an aligned boundary
    property p_col_low;
        @(posedge clk) disable iff (!nrst)
        ev_valid |-> (ev_data.col[1:0] == COL_LOW);
    endproperty
    a_col_low: assert property (p_col_low)
        else $error("event column low bits not zero");

    // with the clock gate low no lane is driven on the next cycle
    property p_gate_off;
        @(posedge ck_t) disable iff (!lrst_n)
        !cke |=> (lane_oe_n == LANE_OFF && $stable(lq.st));
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("lane driven or state moved with clock gate low");

    // a driven read beat always comes with a strobe edge
    property p_strobe;
        @(posedge ck_t) disable iff (!lrst_n)
        (lane_oe_n == LANE_ON) |-> (strobe_t_o != $past(strobe_t_o)
            && strobe_c_o == ~strobe_t_o);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("read data driven without a strobe edge");

    // an inverted lane 0 always carries fewer ones than the limit
    property p_inv;
        @(posedge ck_t) disable iff (!lrst_n)
        (lane_oe_n[0] == 1'b0 && mask_invert_line_o[0]) |->
            ($countones(data_o[LANE_W-1:0]) < DBI_LIM);
    endproperty
    a_inv: assert property (p_inv)
        else $error("lane flagged inverted with too many ones");

    // in mask mode a write beat keeps only lanes whose line was low
    property p_mask;
        @(posedge ck_t) disable iff (!lrst_n)
        (cke && lq.wcnt != WCNT_ZERO && lq.cfg2.dm_en
            && lq.fcnt != EVQ_FULL) |=>
            (lq.fq[$past(lq.wp)].kind == EV_WDAT
            && lq.fq[$past(lq.wp)].be == ~$past(mask_invert_line_i));
    endproperty
    a_mask: assert property (p_mask)
        else $error("write mask not taken from the mask line");

    // termination follows the synchronised pin and the mode bit
    property p_term;
        @(posedge clk) disable iff (!nrst)
        (ce && cq.term2 && term_mode_en) |=> term_on;
    endproperty
    a_term: assert property (p_term)
        else $error("command termination did not turn on");

    // lanes stay released between read beats
    property p_release;
        @(posedge ck_t) disable iff (!lrst_n)
        (lane_oe_n == LANE_ON) |=>
            (lane_oe_n == LANE_OFF || lq.rack != $past(lq.rack));
    endproperty
    a_release: assert property (p_release)
        else $error("lane driven without a read beat");
endmodule : sapi_top
`default_nettype wire

// ---- tb/sapi_host.sv ----
// host controller model driving the link side of the pin interface
`timescale 1ns/1ns
`default_nettype none
module sapi_host
    import sapi_pkg::*;
(
    output logic ck_t,               // link clock, runs free
    output logic cke,                // clock gate
    output logic cs,                 // chip select
    output logic [CA_W-1:0] ca,      // command/address lines
    output logic [DQ_W-1:0] dq,      // write data
    output logic [LANES-1:0] dm      // mask/invert per lane
);
    logic busy;

    // start state; clock offset keeps it unrelated to the core clock
    initial begin
        busy = 1'b0;
        cke = 1'b1;
        cs = 1'b0;
        ca = 6'h15;
        dq = 16'h5A3C;
        dm = 2'h1;
        ck_t = 1'b0;
        #3;
        forever #80 ck_t = ~ck_t;
    end

    // between frames lines keep moving so stale values never pass as data
    always @(posedge ck_t) if (!busy) begin
        ca <= ~ca; // defined levels, never floating
        dq <= ~dq;
        dm <= ~dm;
    end

    // n command halves, select on each first half, then nb write beats
    task frame(input logic [23:0] h, input int n, input int nb,
               input logic [15:0] d, input logic [1:0] m);
        busy = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge ck_t);
            cs <= (i % 2 == 0);
            ca <= h[23 - 6 * i -: 6];
        end
        for (int b = 0; b < nb; b++) begin
            @(posedge ck_t);
            cs <= 1'b0;
            dq <= d ^ 16'(b); // controller drives write data
            dm <= m;
        end
        @(posedge ck_t);
        cs <= 1'b0;
        #1 busy = 1'b0;
    endtask : frame

    // clock gate change on a link edge
    task gate(input logic v);
        @(posedge ck_t);
        cke <= v;
    endtask : gate
endmodule : sapi_host
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the sdram pin interface
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sapi_pkg::*;
    typedef struct packed {
        logic [23:0] h;
        sapi_kind_t k;
        logic [2:0] bank;
        logic [14:0] row;
        logic [9:0] col;
        logic ap;
    } sapi_row_t;
    logic clk, nrst, ck_t, cke, cs, ev_ready, rd_valid, mode_en, tctl;
    logic ev_valid, rd_ready, term_on, ev_overrun;
    logic [CA_W-1:0] ca;
    logic [DQ_W-1:0] dq, data_o, rd_data;
    logic [LANES-1:0] dm, mio, st_t, st_c, oe_n;
    sapi_ev_t ev_data, e;
    sapi_ev_t q[$];
    sapi_row_t rows[4];
    int err_count = 0;
    int checks = 0;

    sapi_host u_host (.ck_t(ck_t), .cke(cke), .cs(cs), .ca(ca), .dq(dq),
        .dm(dm));
    sapi_top u_sapi_top (.clk(clk), .nrst(nrst), .ce(1'b1), .ck_t(ck_t),
        .cke(cke), .cs(cs), .cmd_addr_bus(ca), .data_i(dq), .data_o(data_o),
        .mask_invert_line_i(dm), .mask_invert_line_o(mio),
        .strobe_t_o(st_t), .strobe_c_o(st_c), .lane_oe_n(oe_n),
        .cfg_i(sapi_cfg_t'(3'b101)), .term_mode_en(mode_en),
        .cmd_term_ctl(tctl), .term_on(term_on), .ev_valid(ev_valid),
        .ev_ready(ev_ready), .ev_data(ev_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .ev_overrun(ev_overrun));

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task test_done;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // bounded wait for one event; a missing one shows as EV_NONE
    task getev;
        for (int i = 0; i < 400 && q.size() == 0; i++) @(posedge clk);
        e = q.size() ? q.pop_front() : '1;
    endtask : getev

    task rstchk;
        chk("oe", oe_n, 2'h3); // lanes released
        chk("valid", ev_valid, 0);
        chk("ovr", ev_overrun, 0);
        chk("rdy", rd_ready, 1);
    endtask : rstchk

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // consumer collects every accepted event
    always @(posedge clk) if (ev_valid === 1'b1 && ev_ready === 1'b1)
        q.push_back(ev_data);

    initial begin
        #400000;
        err_count++;
        test_done;
    end

    initial begin
        nrst = 1'b0; ev_ready = 1'b1; rd_valid = 1'b0;
        rd_data = 16'h0; mode_en = 1'b0; tctl = 1'b0;
        rows[0] = {24'h405000, EV_PRE, 3'h5, 15'h0, 10'h0, 1'b0};
        rows[1] = {24'hA00000, EV_REF, 3'h0, 15'h0, 10'h0, 1'b1};
        rows[2] = {24'h0A1204, EV_RD, 3'h2, 15'h0, 10'h354, 1'b1};
        rows[3] = {24'h000000, EV_ACT, 3'h7, 15'h5ABC, 10'h0, 1'b0};
        rows[2].h = {6'h02, 6'h32, 6'h32, 6'h15};
        rows[3].h = {6'h15, 6'h27, 6'h2B, 6'h3C};
        // held past a link edge so the link side resets too
        repeat (20) @(posedge clk);
        rstchk;
        nrst <= 1'b1;
        repeat (70) @(posedge clk);
        foreach (rows[i]) begin
            u_host.frame(rows[i].h, rows[i].k == EV_ACT || rows[i].k == EV_RD
                ? 4 : 2, 0, 16'h0, 2'h0);
            getev;
            chk("kind", e.kind, rows[i].k);
            chk("bank", e.bank, rows[i].bank);
            if (rows[i].k == EV_ACT) chk("row", e.row, rows[i].row);
            else chk("ap", e.ap, rows[i].ap);
            if (rows[i].k == EV_RD) chk("col", e.col, rows[i].col);
        end
        // masked write: eight beats, mask line high drops that lane
        u_host.frame({6'h0C, 6'h04, 6'h12, 6'h10}, 4, 8, 16'hC35A, 2'h2);
        getev;
        chk("mwr", {e.kind, e.bank, e.col}, {EV_MWR, 3'h4, 10'h040});
        for (int b = 0; b < 8; b++) begin
            getev;
            chk("wdat", {e.kind, e.data}, {EV_WDAT, 16'hC35A ^ 16'(b)});
            chk("be", e.be, 2'h1);
        end
        chk("ovr", ev_overrun, 0);
        // read word: lane0 has eight ones so goes inverted, lane1 four
        @(posedge clk) rd_valid <= 1'b1;
        rd_data <= 16'h0FFF;
        @(posedge clk) rd_valid <= 1'b0;
        for (int i = 0; i < 200 && oe_n !== 2'h0; i++) @(posedge clk);
        chk("oe", oe_n, 2'h0);
        chk("dq", data_o, 16'h0F00);
        chk("dmi", mio, 2'h1);
        chk("dqs", {st_t, st_c}, 4'hC);
        chk("rdy", rd_ready, 0);
        // clock gate low: a command on the lines is not decoded
        u_host.gate(1'b0);
        u_host.frame(rows[0].h, 2, 0, 16'h0, 2'h0);
        u_host.gate(1'b1);
        repeat (100) @(posedge clk);
        chk("gated", q.size(), 0);
        chk("rdy", rd_ready, 1);
        @(posedge clk) mode_en <= 1'b1;
        tctl <= 1'b1;
        repeat (6) @(posedge clk);
        chk("term", term_on, 1);
        mode_en <= 1'b0;
        repeat (3) @(posedge clk);
        chk("term", term_on, 0);
        // stalled consumer: buffer, held word and queue take eleven
        ev_ready <= 1'b0;
        repeat (11) u_host.frame(rows[0].h, 2, 0, 16'h0, 2'h0);
        repeat (100) @(posedge clk);
        chk("ovr", ev_overrun, 0);
        u_host.frame(rows[1].h, 2, 0, 16'h0, 2'h0);
        repeat (100) @(posedge clk);
        chk("ovr", ev_overrun, 1);
        nrst <= 1'b0;
        repeat (48) @(posedge clk);
        rstchk;
        test_done;
    end
endmodule : testbench
`default_nettype wire
